// [rtl/bmc_pkg.sv]
// Constants for the bias and monitor configuration register bank
package bmc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] BIAS_PIN_CONFIG_ADDR = 8'h08;
  localparam logic [7:0] MON_CAL_CONTROL_ADDR = 8'h09;
  localparam logic [7:0] BIAS_PIN_CONFIG_RST = 8'h00;
  localparam logic [7:0] MON_CAL_CONTROL_RST = 8'h10;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // ==========================================================
  // Bias register fields
  localparam int BIAS_LEVEL_BIT = 7;
  localparam int BIAS_COMMON_BIT = 6;
  localparam int BIAS_PINS_MSB = 5;
  localparam int BIAS_PINS_LSB = 0;

  // ==========================================================
  // Monitor and calibration register fields
  localparam int MON_SEL_MSB = 7;
  localparam int MON_SEL_LSB = 5;
  localparam int CAL_AVG_MSB = 4;
  localparam int CAL_AVG_LSB = 3;
  localparam int TIMEOUT_EN_BIT = 2;
  localparam int CRC_EN_BIT = 1;
  localparam int STATUS_EN_BIT = 0;

  // ==========================================================
  // Monitor codes
  localparam logic [2:0] MON_OFF = 3'h0;
  localparam logic [2:0] MON_MID_SHORT = 3'h1;
  localparam logic [2:0] MON_TEMP = 3'h2;
  localparam logic [2:0] MON_ANALOG_SUPPLY = 3'h3;
  localparam logic [2:0] MON_DIGITAL_SUPPLY = 3'h4;
  localparam logic [2:0] MON_BURNOUT_LOW = 3'h5;
  localparam logic [2:0] MON_BURNOUT_MID = 3'h6;
  localparam logic [2:0] MON_BURNOUT_HIGH = 3'h7;

  // Burn-out current levels on burnout_level_o
  localparam logic [1:0] BURNOUT_0P2_UA = 2'h0;
  localparam logic [1:0] BURNOUT_1_UA = 2'h1;
  localparam logic [1:0] BURNOUT_10_UA = 2'h2;

  // Supply monitor select on supply_monitor_sel_o
  localparam logic [1:0] SUPPLY_NONE = 2'h0;
  localparam logic [1:0] SUPPLY_ANALOG = 2'h1;
  localparam logic [1:0] SUPPLY_DIGITAL = 2'h2;

  // ==========================================================
  // Calibration averaging codes and sample counts
  localparam logic [1:0] CAL_AVG_1 = 2'h0;
  localparam logic [1:0] CAL_AVG_4 = 2'h1;
  localparam logic [1:0] CAL_AVG_8 = 2'h2;
  localparam logic [1:0] CAL_AVG_16 = 2'h3;
  localparam logic [4:0] CAL_SAMPLES_1 = 5'h01;
  localparam logic [4:0] CAL_SAMPLES_4 = 5'h04;
  localparam logic [4:0] CAL_SAMPLES_8 = 5'h08;
  localparam logic [4:0] CAL_SAMPLES_16 = 5'h10;

endpackage

// [rtl/bmc_cfg_reg.sv]
// One 8-bit read/write configuration register with a reset value
`timescale 1ns/10ps
`default_nettype none

module bmc_cfg_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] value_o
);

  // ==========================================================
  // Storage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      value_o <= RESET_VALUE;
    end else if (wr_en_i) begin
      value_o <= wr_data_i;
    end
  end

endmodule // bmc_cfg_reg

`default_nettype wire

// [rtl/bmc_config_regs.sv]
// Bias pin and monitor/calibration configuration register bank
`timescale 1ns/10ps
`default_nettype none

module bmc_config_regs (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic bias_gen_enable_o,
  output logic bias_level_select_o,
  output logic bias_on_common_input_o,
  output logic [5:0] bias_on_analog_input_pin_o,
  output logic [2:0] monitor_select_o,
  output logic mid_supply_short_o,
  output logic temp_sensor_enable_o,
  output logic [1:0] supply_monitor_sel_o,
  output logic gain_force_one_o,
  output logic input_mux_open_o,
  output logic burnout_enable_o,
  output logic [1:0] burnout_level_o,
  output logic [4:0] cal_average_count_o,
  output logic timeout_enable_o,
  output logic crc_enable_o,
  output logic prepend_status_byte_o
);

  // ==========================================================
  // Register storage
  logic [7:0] bias_pin_config_reg;
  logic [7:0] monitor_and_cal_control_reg;
  logic bias_wr;
  logic mon_wr;

  assign bias_wr = wr_en_i && (addr_i == bmc_pkg::BIAS_PIN_CONFIG_ADDR);
  assign mon_wr = wr_en_i && (addr_i == bmc_pkg::MON_CAL_CONTROL_ADDR);

  // Whole byte written, every bit free
  bmc_cfg_reg #(
    .RESET_VALUE(bmc_pkg::BIAS_PIN_CONFIG_RST)
  ) u_bias_pin_config (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(bias_wr),
    .wr_data_i(wr_data_i),
    .value_o(bias_pin_config_reg)
  );

  // Monitor and calibration control
  bmc_cfg_reg #(
    .RESET_VALUE(bmc_pkg::MON_CAL_CONTROL_RST)
  ) u_monitor_and_cal_control (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wr_en_i(mon_wr),
    .wr_data_i(wr_data_i),
    .value_o(monitor_and_cal_control_reg)
  );

  // ==========================================================
  // Read port
  logic [7:0] rd_data_next;

  always_comb begin
    rd_data_next = bmc_pkg::UNMAPPED_READ_VALUE;
    if (addr_i == bmc_pkg::BIAS_PIN_CONFIG_ADDR) begin
      rd_data_next = bias_pin_config_reg;
    end else if (addr_i == bmc_pkg::MON_CAL_CONTROL_ADDR) begin
      rd_data_next = monitor_and_cal_control_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i) begin
        rd_data_o <= rd_data_next;
      end
    end
  end

  // ==========================================================
  // Bias control
  logic [6:0] bias_conn;

  assign bias_conn = bias_pin_config_reg[bmc_pkg::BIAS_COMMON_BIT:
                                         bmc_pkg::BIAS_PINS_LSB];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bias_gen_enable_o <= 1'b0;
      bias_level_select_o <= 1'b0;
      bias_on_common_input_o <= 1'b0;
      bias_on_analog_input_pin_o <= 6'h00;
    end else begin
      bias_gen_enable_o <= |bias_conn;
      bias_level_select_o <=
        bias_pin_config_reg[bmc_pkg::BIAS_LEVEL_BIT];
      bias_on_common_input_o <=
        bias_pin_config_reg[bmc_pkg::BIAS_COMMON_BIT];
      bias_on_analog_input_pin_o <=
        bias_pin_config_reg[bmc_pkg::BIAS_PINS_MSB:
                            bmc_pkg::BIAS_PINS_LSB];
    end
  end

  // ==========================================================
  // Monitor decode
  logic [2:0] mon_code;

  assign mon_code = monitor_and_cal_control_reg[bmc_pkg::MON_SEL_MSB:
                                                bmc_pkg::MON_SEL_LSB];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      monitor_select_o <= 3'h0;
      mid_supply_short_o <= 1'b0;
      temp_sensor_enable_o <= 1'b0;
      supply_monitor_sel_o <= 2'h0;
      gain_force_one_o <= 1'b0;
      input_mux_open_o <= 1'b0;
      burnout_enable_o <= 1'b0;
      burnout_level_o <= 2'h0;
    end else begin
      monitor_select_o <= mon_code;
      mid_supply_short_o <= (mon_code == bmc_pkg::MON_MID_SHORT);
      // Amplifier enable stays with the host
      temp_sensor_enable_o <= (mon_code == bmc_pkg::MON_TEMP);
      gain_force_one_o <= (mon_code == bmc_pkg::MON_ANALOG_SUPPLY) ||
                          (mon_code == bmc_pkg::MON_DIGITAL_SUPPLY);
      input_mux_open_o <= (mon_code != bmc_pkg::MON_OFF) &&
                          (mon_code < bmc_pkg::MON_BURNOUT_LOW);
      burnout_enable_o <= (mon_code >= bmc_pkg::MON_BURNOUT_LOW);
      unique case (mon_code)
        bmc_pkg::MON_ANALOG_SUPPLY: begin
          supply_monitor_sel_o <= bmc_pkg::SUPPLY_ANALOG;
        end
        bmc_pkg::MON_DIGITAL_SUPPLY: begin
          supply_monitor_sel_o <= bmc_pkg::SUPPLY_DIGITAL;
        end
        default: begin
          supply_monitor_sel_o <= bmc_pkg::SUPPLY_NONE;
        end
      endcase
      unique case (mon_code)
        bmc_pkg::MON_BURNOUT_MID: begin
          burnout_level_o <= bmc_pkg::BURNOUT_1_UA;
        end
        bmc_pkg::MON_BURNOUT_HIGH: begin
          burnout_level_o <= bmc_pkg::BURNOUT_10_UA;
        end
        default: begin
          burnout_level_o <= bmc_pkg::BURNOUT_0P2_UA;
        end
      endcase
    end
  end

  // ==========================================================
  // Calibration averaging and readout options
  logic [1:0] cal_code;

  assign cal_code = monitor_and_cal_control_reg[bmc_pkg::CAL_AVG_MSB:
                                                bmc_pkg::CAL_AVG_LSB];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cal_average_count_o <= bmc_pkg::CAL_SAMPLES_8;
      timeout_enable_o <= 1'b0;
      crc_enable_o <= 1'b0;
      prepend_status_byte_o <= 1'b0;
    end else begin
      unique case (cal_code)
        bmc_pkg::CAL_AVG_1: cal_average_count_o <= bmc_pkg::CAL_SAMPLES_1;
        bmc_pkg::CAL_AVG_4: cal_average_count_o <= bmc_pkg::CAL_SAMPLES_4;
        bmc_pkg::CAL_AVG_8: cal_average_count_o <= bmc_pkg::CAL_SAMPLES_8;
        bmc_pkg::CAL_AVG_16: cal_average_count_o <= bmc_pkg::CAL_SAMPLES_16;
      endcase
      timeout_enable_o <=
        monitor_and_cal_control_reg[bmc_pkg::TIMEOUT_EN_BIT];
      crc_enable_o <=
        monitor_and_cal_control_reg[bmc_pkg::CRC_EN_BIT];
      prepend_status_byte_o <=
        monitor_and_cal_control_reg[bmc_pkg::STATUS_EN_BIT];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  bias_write_read_a: assert property (
    bias_wr ##1 (rd_en_i && addr_i == bmc_pkg::BIAS_PIN_CONFIG_ADDR)
    |=> rd_data_o == $past(wr_data_i, 2))
    else $error("bias register readback differs from write");

  mon_write_read_a: assert property (
    mon_wr ##1 (rd_en_i && addr_i == bmc_pkg::MON_CAL_CONTROL_ADDR)
    |=> rd_data_o == $past(wr_data_i, 2))
    else $error("monitor register readback differs from write");

  unmapped_read_zero_a: assert property (
    (rd_en_i && addr_i != bmc_pkg::BIAS_PIN_CONFIG_ADDR &&
     addr_i != bmc_pkg::MON_CAL_CONTROL_ADDR)
    |=> rd_valid_o && rd_data_o == 8'h00)
    else $error("unmapped read not zero");

  bias_gen_off_a: assert property (
    (bias_wr && wr_data_i[6:0] == 7'h00) ##1 !bias_wr |=>
    !bias_gen_enable_o)
    else $error("bias generator on with no pin selected");

  bias_pins_follow_a: assert property (
    bias_wr ##1 1'b1 |=> bias_on_analog_input_pin_o == $past(wr_data_i[5:0], 2)
    && bias_level_select_o == $past(wr_data_i[7], 2))
    else $error("bias pin outputs do not follow write");

  gain_forced_a: assert property (
    gain_force_one_o |-> supply_monitor_sel_o != bmc_pkg::SUPPLY_NONE
    && input_mux_open_o && !burnout_enable_o)
    else $error("gain forced outside supply monitor");

  mux_open_a: assert property (
    (mid_supply_short_o || temp_sensor_enable_o) |-> input_mux_open_o)
    else $error("input mux closed during monitor");

  burnout_level_a: assert property (
    (mon_wr && wr_data_i[7:5] == bmc_pkg::MON_BURNOUT_HIGH) ##1 !mon_wr
    |=> burnout_enable_o && burnout_level_o == bmc_pkg::BURNOUT_10_UA)
    else $error("burn-out level wrong for highest code");

  cal_count_a: assert property (
    (mon_wr && wr_data_i[4:3] == bmc_pkg::CAL_AVG_1) ##1 !mon_wr
    |=> cal_average_count_o == 5'h01)
    else $error("calibration average not one sample");

  mon_off_a: assert property (
    monitor_select_o == bmc_pkg::MON_OFF |-> !input_mux_open_o &&
    !burnout_enable_o && !mid_supply_short_o && !temp_sensor_enable_o)
    else $error("monitor function active while off");

  cover_multi_bias_c: cover property (bias_gen_enable_o &&
    bias_on_common_input_o && (&bias_on_analog_input_pin_o));
  cover_temp_c: cover property (temp_sensor_enable_o);
  cover_burnout_c: cover property (burnout_enable_o &&
    burnout_level_o == bmc_pkg::BURNOUT_1_UA);
  cover_options_c: cover property (crc_enable_o && prepend_status_byte_o
    && timeout_enable_o);

endmodule // bmc_config_regs

`default_nettype wire

// [test/bmc_host_model.sv]
// Host model that drives the register strobes of the config bank
`timescale 1ns/10ps
`default_nettype none

module bmc_host_model (
  input wire logic clk_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wr_data_o,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'hFF;
    wr_data_o = 8'hFF;
  end

  // ==========================================================
  // Bus cycles, lines inverted once released
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wr_data_o <= d;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    addr_o <= ~a;
    wr_data_o <= ~d;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    // Valid stands one cycle right after the strobe edge
    repeat (4) begin
      #1;
      if (!ok && rd_valid_i === 1'b1) begin
        ok = 1'b1;
        d = rd_data_i;
      end
      @(posedge clk_i);
    end
  endtask

  // Write strobe followed directly by a read strobe
  task automatic write_read(input logic [7:0] a, input logic [7:0] wd,
                            output logic [7:0] rd, output logic ok);
    ok = 1'b0;
    rd = 8'h00;
    @(posedge clk_i);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wr_data_o <= wd;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    wr_data_o <= ~wd;
    rd_en_o <= 1'b1;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    #1;
    if (rd_valid_i === 1'b1) begin
      ok = 1'b1;
      rd = rd_data_i;
    end
    @(posedge clk_i);
  endtask
endmodule // bmc_host_model
`default_nettype wire

// [test/bias_and_monitor_config_regs_test.sv]
// Testbench for the bias and monitor configuration register bank
`timescale 1ns/10ps
`default_nettype none

module bias_and_monitor_config_regs_test;
  logic clk_i, rstn_i, wr_en_i, rd_en_i, rd_valid_o;
  logic [7:0] addr_i, wr_data_i, rd_data_o;
  logic bias_gen_enable_o, bias_level_select_o, bias_on_common_input_o;
  logic [5:0] bias_on_analog_input_pin_o;
  logic [2:0] monitor_select_o;
  logic mid_supply_short_o, temp_sensor_enable_o, gain_force_one_o;
  logic input_mux_open_o, burnout_enable_o;
  logic [1:0] supply_monitor_sel_o, burnout_level_o;
  logic [4:0] cal_average_count_o;
  logic timeout_enable_o, crc_enable_o, prepend_status_byte_o;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  logic [4:0] cal_tab [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
  logic [7:0] bias_tab [7] = '{8'h80, 8'h40, 8'h01, 8'h3F, 8'h7F, 8'hFF,
                               8'h00};

  bmc_config_regs bmc_config_regs_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .bias_gen_enable_o(bias_gen_enable_o),
    .bias_level_select_o(bias_level_select_o),
    .bias_on_common_input_o(bias_on_common_input_o),
    .bias_on_analog_input_pin_o(bias_on_analog_input_pin_o),
    .monitor_select_o(monitor_select_o),
    .mid_supply_short_o(mid_supply_short_o),
    .temp_sensor_enable_o(temp_sensor_enable_o),
    .supply_monitor_sel_o(supply_monitor_sel_o),
    .gain_force_one_o(gain_force_one_o),
    .input_mux_open_o(input_mux_open_o),
    .burnout_enable_o(burnout_enable_o), .burnout_level_o(burnout_level_o),
    .cal_average_count_o(cal_average_count_o),
    .timeout_enable_o(timeout_enable_o), .crc_enable_o(crc_enable_o),
    .prepend_status_byte_o(prepend_status_byte_o));

  bmc_host_model bmc_host_model_i (.clk_i(clk_i), .wr_en_o(wr_en_i),
    .rd_en_o(rd_en_i), .addr_o(addr_i), .wr_data_o(wr_data_i),
    .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o));

  // ==========================================================
  // Clock, reset and hang limit
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      summarize();
    end
  end

  // ==========================================================
  // Shared helpers
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    bmc_host_model_i.read(a, d, ok);
    check({7'h00, ok}, 8'h01, "read answer");
    check(d, exp, "read data");
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_values();
    check({3'h0, cal_average_count_o}, 8'h08, "cal count");
    check({7'h00, bias_gen_enable_o}, 8'h00, "bias gen");
    check({5'h00, monitor_select_o}, 8'h00, "monitor");
    check({5'h00, timeout_enable_o, crc_enable_o, prepend_status_byte_o},
          8'h00, "enables");
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h09, 8'h10);
  endtask

  task automatic t_bias();
    logic [7:0] v;
    foreach (bias_tab[i]) begin
      v = bias_tab[i];
      bmc_host_model_i.write(8'h08, v);
      settle();
      check({7'h00, bias_gen_enable_o}, {7'h00, |v[6:0]}, "gen");
      check({7'h00, bias_level_select_o}, {7'h00, v[7]}, "level");
      check({1'b0, bias_on_common_input_o, bias_on_analog_input_pin_o},
            {1'b0, v[6:0]}, "pins");
      rd_chk(8'h08, v);
    end
  endtask

  task automatic t_monitor();
    logic [7:0] v;
    logic [2:0] c;
    for (int k = 0; k < 8; k++) begin
      c = k[2:0];
      v = {c, c[1:0], c};
      // Temperature code also needs amp_enable set elsewhere
      bmc_host_model_i.write(8'h09, v);
      settle();
      check({5'h00, monitor_select_o}, {5'h00, c}, "code");
      check({4'h0, mid_supply_short_o, temp_sensor_enable_o,
             input_mux_open_o, gain_force_one_o},
            {4'h0, c == 3'h1, c == 3'h2, c >= 3'h1 && c <= 3'h4,
             c == 3'h3 || c == 3'h4}, "monitor");
      check({6'h00, supply_monitor_sel_o},
            {6'h00, c == 3'h4, c == 3'h3}, "supply");
      check({5'h00, burnout_enable_o, burnout_level_o},
            {5'h00, c >= 3'h5, c == 3'h7, c == 3'h6}, "burnout");
      check({3'h0, cal_average_count_o}, {3'h0, cal_tab[c[1:0]]},
            "cal");
      check({5'h00, timeout_enable_o, crc_enable_o, prepend_status_byte_o},
            {5'h00, c}, "enables");
      rd_chk(8'h09, v);
    end
  endtask

  task automatic t_unmapped();
    bmc_host_model_i.write(8'h0A, 8'h55);
    bmc_host_model_i.write(8'h07, 8'hAA);
    settle();
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h09, 8'hFF);
    rd_chk(8'h0A, 8'h00);
  endtask

  task automatic t_back_to_back();
    logic [7:0] d;
    logic ok;
    bmc_host_model_i.write_read(8'h08, 8'h5A, d, ok);
    check({7'h00, ok}, 8'h01, "bias wr-rd answer");
    check(d, 8'h5A, "bias wr-rd data");
    bmc_host_model_i.write_read(8'h09, 8'hA5, d, ok);
    check({7'h00, ok}, 8'h01, "monitor wr-rd answer");
    check(d, 8'hA5, "monitor wr-rd data");
  endtask

  task automatic t_mid_reset();
    bmc_host_model_i.write(8'h08, 8'hC3);
    bmc_host_model_i.write(8'h09, 8'h07);
    settle();
    @(posedge clk_i);
    rstn_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check({7'h00, bias_gen_enable_o}, 8'h00, "gen in reset");
    check({3'h0, cal_average_count_o}, 8'h08, "cal in reset");
    @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    #1;
    t_reset_values();
  endtask

  initial begin
    rstn_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    #1;
    t_reset_values();
    t_bias();
    t_monitor();
    t_unmapped();
    t_back_to_back();
    t_mid_reset();
    summarize();
  end
endmodule // bias_and_monitor_config_regs_test
`default_nettype wire
